/* File: logic/dcm_defs.vh */
// What this block does
// R1: In normal mode the instruction tick is the high clock divided by a build-time N of 1 to 8.
// R2: In slow mode the instruction tick is the low oscillator clock divided by four.
// R3: With the noise filter built in, the high-clock divider never goes beyond four.
// R4: Mode register bit 1 stops the high oscillator when set; the low oscillator keeps running.
// R5: Mode register bit 2 picks the high clock when zero and the low clock when one.
// R6: Mode field bits 4:3 pick normal 00, sleep 01, green 10, with 11 reserved.
// R7: Sleep stops both the high and the low oscillator.
// R8: The low oscillator stops only in sleep, or in green on the low clock with watchdog off.
// R9: No separate control exists to stop the low oscillator.
// R10: The low oscillator clocks the watchdog and the slow-mode system clock.
// R11: The high-clock type is RC, 12M crystal or 4M crystal; RC turns the second pin into GPIO.
// R12: With the RC type an external clock on the oscillator input pin is the high clock.
// R13: Reset is lengthened by the start-up time of the chosen high-clock oscillator type.
// R14: Either the high or the low clock may be the system clock.
// R15: Reset clears mode field, clock select and stop bit; unused bits read as zero.
// R16: The reserved mode code behaves as normal mode.
// R17: Wake from sleep waits 2048 high clocks before normal mode; wake from green waits none.
//
// Purpose: constants of the dual clock mode control block
// Assumes: included by its bare name
// Notes: definitions only
`ifndef DCM_DEFS_VH
`define DCM_DEFS_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define DCM_OSC_MODE_IDX 12'h0CA
`define DCM_OSC_MODE_ADDR (`DCM_OSC_MODE_IDX * 12'h004)
`define DCM_OSC_MODE_RST 8'h00
`define DCM_OSC_MODE_MASK 8'h1E

// ----------------------------------------
// field positions
// ----------------------------------------
`define DCM_STOP_BIT 1
`define DCM_CLKSEL_BIT 2
`define DCM_MODE_LSB 3
`define DCM_MODE_MSB 4

// ----------------------------------------
// mode codes
// ----------------------------------------
`define DCM_MODE_NORMAL 2'h0
`define DCM_MODE_SLEEP 2'h1
`define DCM_MODE_GREEN 2'h2
`define DCM_MODE_RSVD 2'h3

// ----------------------------------------
// oscillator types and counts
// ----------------------------------------
`define DCM_TYPE_RC 2'h0
`define DCM_TYPE_12M 2'h1
`define DCM_TYPE_4M 2'h2
`define DCM_DIV_MAX 4'h8
`define DCM_DIV_FILT_MAX 4'h4
`define DCM_SLOW_DIV 4'h4
`define DCM_WAKE_CLKS 2048
`define DCM_START_RC 16
`define DCM_START_XTAL 4096

`endif

/* File: logic/dcm_tick_div.v */
// Purpose: counts enable pulses and emits one tick per div pulses
// Assumes: div in 1..15, en is a one-cycle pulse
// Notes: tick is registered
`timescale 1ns/1ps
module dcm_tick_div #(
    parameter W = 4
) (
    input wire ref_clk,
    input wire arst_n,
    input wire en,
    input wire clr,
    input wire [W-1:0] div,
    output reg tick_q
);

reg [W-1:0] cnt_q;
reg [W-1:0] cnt_d;
reg tick_d;

// ----------------------------------------
// pulse counter
// ----------------------------------------
always @* begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (clr) begin
        cnt_d = {W{1'b0}};
    end else if (en) begin
        if (cnt_q >= div - {{(W-1){1'b0}}, 1'b1}) begin
            cnt_d = {W{1'b0}};
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
    end
end

always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
        cnt_q <= {W{1'b0}};
        tick_q <= 1'b0;
    end else begin
        cnt_q <= cnt_d;
        tick_q <= tick_d;
    end
end

endmodule // dcm_tick_div

/* File: logic/dcm_clock_ctrl.v */
// Purpose: system clock and operating mode control with an AHB-Lite register slave
// Assumes: oscillator inputs are sampled levels synchronous to ref_clk
// Notes: instruction rate leaves as a one-cycle tick, not a gated clock
`timescale 1ns/1ps
`include "dcm_defs.vh"
module dcm_clock_ctrl #(
    parameter [1:0] HCLK_TYPE = `DCM_TYPE_4M,
    parameter [3:0] CPU_DIV = 4'h4,
    parameter NOISE_FILTER = 1,
    parameter START_RC = `DCM_START_RC,
    parameter START_XTAL = `DCM_START_XTAL,
    parameter WAKE_CLKS = `DCM_WAKE_CLKS
) (
    input wire ref_clk,
    input wire arst_n,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    input wire osc_input_pin,
    input wire low_osc_in,
    input wire wdt_en,
    input wire wake_req,
    output wire high_osc_run,
    output wire low_osc_run,
    output wire sys_clk_low,
    output wire [1:0] cpu_mode_field,
    output reg cpu_tick_q,
    output reg wdt_tick_q,
    output reg cpu_run_q,
    output wire osc_out_is_gpio
);

localparam S_RST_WAIT = 2'h0;
localparam S_RUN = 2'h1;
localparam S_WAKE_WAIT = 2'h2;
localparam [3:0] DIV_EFF = (NOISE_FILTER != 0 && CPU_DIV > `DCM_DIV_FILT_MAX) ?
    `DCM_DIV_FILT_MAX : ((CPU_DIV > `DCM_DIV_MAX) ? `DCM_DIV_MAX :
    ((CPU_DIV == 4'h0) ? 4'h1 : CPU_DIV));
localparam [15:0] START_CLKS = (HCLK_TYPE == `DCM_TYPE_RC) ? START_RC[15:0] :
    START_XTAL[15:0];
localparam [15:0] WAKE_CNT = WAKE_CLKS[15:0];

// ----------------------------------------
// bus slave
// ----------------------------------------
reg wr_pend_q;
reg [11:0] addr_q;
wire addr_hit;
wire req;
wire wr_now;
reg [7:0] osc_mode_q;
reg [7:0] osc_mode_d;
reg [1:0] state_q;
reg [1:0] state_d;
reg [15:0] cnt_q;
reg [15:0] cnt_d;
reg edge_arm_q;
wire [1:0] osc_level;
wire [1:0] osc_gate;
wire [1:0] osc_rise;
wire high_osc_option_edge;
wire losc_edge;
wire [1:0] mode_raw;
wire mode_sleep;
wire mode_green;
wire high_osc_option_on;
wire losc_on;
wire normal_en;
wire slow_en;
wire normal_tick;
wire slow_tick;
wire rd_req;
wire wr_req;
wire mode_exec;
reg [2:0] mode_dec;
reg [31:0] rd_word;

assign hreadyout = 1'b1;
assign hresp = 1'b0;
assign req = hsel && htrans[1] && hready;
assign addr_hit = (haddr[31:12] == 20'h00000) && (haddr[11:0] == `DCM_OSC_MODE_ADDR);
assign wr_now = wr_pend_q && (addr_q == `DCM_OSC_MODE_ADDR);
assign rd_req = req && !hwrite;
assign wr_req = req && hwrite && addr_hit;

always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
        wr_pend_q <= 1'b0;
        addr_q <= 12'h000;
    end else if (hready) begin
        wr_pend_q <= wr_req;
        addr_q <= haddr[11:0];
    end
end

// ----------------------------------------
// read mux
// ----------------------------------------
always @* begin
    rd_word = 32'h00000000;
    if (addr_hit) begin
        rd_word = {24'h000000, osc_mode_d}; // R15
    end
end

// read data latched at the address phase, forwarding a write in flight
always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
        hrdata <= 32'h00000000;
    end else if (rd_req) begin
        hrdata <= rd_word;
    end
end

// ----------------------------------------
// mode register
// ----------------------------------------
assign mode_raw = osc_mode_q[`DCM_MODE_MSB:`DCM_MODE_LSB];
assign mode_exec = mode_dec[0];
assign mode_sleep = mode_dec[1];
assign mode_green = mode_dec[2];
assign cpu_mode_field = mode_raw;

// ----------------------------------------
// mode decode
// ----------------------------------------
always @* begin
    mode_dec = 3'h1;
    case (mode_raw)
        `DCM_MODE_NORMAL: begin
            mode_dec = 3'h1; // R6
        end
        `DCM_MODE_SLEEP: begin
            mode_dec = 3'h2; // R6 R7
        end
        `DCM_MODE_GREEN: begin
            mode_dec = 3'h4; // R6
        end
        `DCM_MODE_RSVD: begin
            mode_dec = 3'h1; // R16
        end
        default: begin
            mode_dec = 3'h1;
        end
    endcase
end

always @* begin
    osc_mode_d = osc_mode_q;
    if (wr_now) begin
        osc_mode_d = hwdata[7:0] & `DCM_OSC_MODE_MASK; // R15
    end
    if (wake_req && mode_green) begin
        osc_mode_d[`DCM_MODE_MSB:`DCM_MODE_LSB] = `DCM_MODE_NORMAL; // R17
    end
    if (wake_req && mode_sleep) begin
        osc_mode_d = `DCM_OSC_MODE_RST; // R17
    end
end

always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
        osc_mode_q <= `DCM_OSC_MODE_RST; // R15
    end else begin
        osc_mode_q <= osc_mode_d;
    end
end

// ----------------------------------------
// oscillator control
// ----------------------------------------
assign high_osc_option_on = !osc_mode_q[`DCM_STOP_BIT] && !mode_sleep; // R4 R7
assign losc_on = !mode_sleep &&
    !(mode_green && osc_mode_q[`DCM_CLKSEL_BIT] && !wdt_en); // R8 R9
assign high_osc_run = high_osc_option_on;
assign low_osc_run = losc_on;
assign sys_clk_low = osc_mode_q[`DCM_CLKSEL_BIT]; // R5 R14
assign osc_out_is_gpio = (HCLK_TYPE == `DCM_TYPE_RC); // R11

// high clock taken from the input pin in every type, external clock in RC
assign osc_level = {low_osc_in, osc_input_pin}; // R12
assign osc_gate = {losc_on, high_osc_option_on};

// ----------------------------------------
// oscillator edge detect
// ----------------------------------------
// no edge in the first cycle out of reset
always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
        edge_arm_q <= 1'b0;
    end else begin
        edge_arm_q <= 1'b1;
    end
end

genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_osc
        reg prev_q;
        always @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                prev_q <= 1'b0;
            end else begin
                prev_q <= osc_level[gi];
            end
        end
        assign osc_rise[gi] = osc_level[gi] && !prev_q && osc_gate[gi] && edge_arm_q;
    end
endgenerate

assign high_osc_option_edge = osc_rise[0];
assign losc_edge = osc_rise[1];

// ----------------------------------------
// start-up and wake wait
// ----------------------------------------
always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
        S_RST_WAIT: begin
            if (high_osc_option_edge) begin
                if (cnt_q >= START_CLKS - 16'h0001) begin
                    state_d = S_RUN; // R13
                    cnt_d = 16'h0000;
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                end
            end
        end
        S_RUN: begin
            if (wake_req && mode_sleep) begin
                state_d = S_WAKE_WAIT; // R17
                cnt_d = 16'h0000;
            end
        end
        S_WAKE_WAIT: begin
            if (high_osc_option_edge) begin
                if (cnt_q >= WAKE_CNT - 16'h0001) begin
                    state_d = S_RUN; // R17
                    cnt_d = 16'h0000;
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                end
            end
        end
        default: begin
            state_d = S_RST_WAIT;
            cnt_d = 16'h0000;
        end
    endcase
end

always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
        state_q <= S_RST_WAIT;
        cnt_q <= 16'h0000;
    end else begin
        state_q <= state_d;
        cnt_q <= cnt_d;
    end
end

// ----------------------------------------
// instruction rate
// ----------------------------------------
// reserved mode code runs as normal
assign normal_en = high_osc_option_edge && (state_q == S_RUN) && mode_exec &&
    !osc_mode_q[`DCM_CLKSEL_BIT]; // R16
assign slow_en = losc_edge && (state_q == S_RUN) && mode_exec &&
    osc_mode_q[`DCM_CLKSEL_BIT]; // R16

dcm_tick_div #(
    .W(4)
) u_normal_div (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .en(normal_en),
    .clr(osc_mode_q[`DCM_CLKSEL_BIT]),
    .div(DIV_EFF),
    .tick_q(normal_tick)
); // R1 R3

dcm_tick_div #(
    .W(4)
) u_slow_div (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .en(slow_en),
    .clr(!osc_mode_q[`DCM_CLKSEL_BIT]),
    .div(`DCM_SLOW_DIV),
    .tick_q(slow_tick)
); // R2

always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
        cpu_tick_q <= 1'b0;
        wdt_tick_q <= 1'b0;
        cpu_run_q <= 1'b0;
    end else begin
        cpu_tick_q <= normal_tick || slow_tick;
        wdt_tick_q <= losc_edge; // R10
        cpu_run_q <= (state_d == S_RUN); // R13
    end
end

endmodule // dcm_clock_ctrl

/* File: testbench/dcm_chk.sv */
// Purpose: port assertions for the clock control block
// Assumes: bound to dcm_clock_ctrl
// Notes: one clock domain
`timescale 1ns/1ps
module dcm_chk (
    input wire ref_clk,
    input wire arst_n,
    input wire hreadyout,
    input wire hresp,
    input wire wake_req,
    input wire wdt_en,
    input wire high_osc_run,
    input wire low_osc_run,
    input wire sys_clk_low,
    input wire [1:0] cpu_mode_field,
    input wire cpu_tick_q,
    input wire wdt_tick_q,
    input wire cpu_run_q
);
    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
    a_sleep_stop: assert property (cpu_mode_field == 2'h1 |-> !high_osc_run && !low_osc_run)
        else $error("oscillator runs in sleep");
    a_low_osc: assert property (low_osc_run == (cpu_mode_field != 2'h1 &&
        !(cpu_mode_field == 2'h2 && sys_clk_low && !wdt_en))) else $error("low osc enable wrong");
    a_tick_single: assert property (cpu_tick_q |=> !cpu_tick_q) else $error("tick too long");
    a_idle_tick: assert property ((cpu_mode_field inside {2'h1, 2'h2})[*3] |-> !cpu_tick_q)
        else $error("tick while halted");
    a_wdt_stop: assert property ((!low_osc_run)[*3] |-> !wdt_tick_q)
        else $error("watchdog tick without low osc");
    a_sleep_wake: assert property (cpu_mode_field == 2'h1 && wake_req |=>
        cpu_mode_field == 2'h0 && !sys_clk_low ##1 !cpu_run_q) else $error("sleep wake wrong");
    a_green_wake: assert property (cpu_mode_field == 2'h2 && wake_req |=>
        cpu_mode_field == 2'h0 && $stable(sys_clk_low) && $stable(cpu_run_q))
        else $error("green wake wrong");
    c_sleep_wake: cover property (cpu_mode_field == 2'h1 && wake_req);
    c_green_wake: cover property (cpu_mode_field == 2'h2 && wake_req);
    c_slow_tick: cover property (sys_clk_low && cpu_tick_q);
endmodule // dcm_chk
bind dcm_clock_ctrl dcm_chk u_chk (.ref_clk(ref_clk), .arst_n(arst_n),
    .hreadyout(hreadyout), .hresp(hresp), .wake_req(wake_req), .wdt_en(wdt_en),
    .high_osc_run(high_osc_run), .low_osc_run(low_osc_run), .sys_clk_low(sys_clk_low),
    .cpu_mode_field(cpu_mode_field), .cpu_tick_q(cpu_tick_q), .wdt_tick_q(wdt_tick_q),
    .cpu_run_q(cpu_run_q));

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for the clock control block
// Assumes: divider 6 clamped to 4 by the filter, short start and wake counts
// Notes: high osc edge every 2 cycles, low osc edge every 16
`timescale 1ns/1ps
`include "dcm_defs.vh"
module tb_top;
    logic ref_clk = 0, arst_n = 0, hsel = 0, hwrite = 0, osc_in = 0, low_in = 0;
    logic wdt_en = 1, wake_req = 0, hrdy, hresp, hi_run, lo_run, slow, tick, wtick, run, gpio;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0] htrans = 0, mode;
    logic [2:0] hsize = 3'h2, lcnt = 0;
    int miscompares = 0, samples_checked = 0;
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        osc_in <= ~osc_in;
        lcnt <= lcnt + 3'h1;
        if (lcnt == 3'h7) low_in <= ~low_in;
    end
    dcm_clock_ctrl #(.HCLK_TYPE(`DCM_TYPE_4M), .CPU_DIV(4'h6), .NOISE_FILTER(1),
        .START_RC(4), .START_XTAL(8), .WAKE_CLKS(16)) dut (.ref_clk(ref_clk),
        .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp),
        .hrdata(hrdata), .osc_input_pin(osc_in), .low_osc_in(low_in), .wdt_en(wdt_en),
        .wake_req(wake_req), .high_osc_run(hi_run), .low_osc_run(lo_run),
        .sys_clk_low(slow), .cpu_mode_field(mode), .cpu_tick_q(tick), .wdt_tick_q(wtick),
        .cpu_run_q(run), .osc_out_is_gpio(gpio));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic summarize;
        if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wait_rdy;
        int k;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (hrdy !== 1'b1 && k < 50);
        check("hready", hrdy, 1);
        check("hresp", hresp, 0);
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_rdy();
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        @(posedge ref_clk);
    endtask
    task automatic gap(input string nm, input logic w, input logic [31:0] exp);
        int k;
        k = 0;
        @(posedge ref_clk);
        while ((w ? wtick : tick) !== 1'b1 && k < 400) begin
            @(posedge ref_clk);
            k++;
        end
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while ((w ? wtick : tick) !== 1'b1 && k < 400);
        check(nm, k, exp);
    endtask
    task automatic wait_run;
        int k;
        k = 0;
        while (run !== 1'b1 && k < 200) begin
            @(posedge ref_clk);
            k++;
        end
        check("run", run, 1);
    endtask
    task automatic wake;
        wake_req <= 1;
        @(posedge ref_clk);
        wake_req <= 0;
        @(posedge ref_clk);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        check("run_rst", run, 0);
        ahb(0, `DCM_OSC_MODE_ADDR, 0);
        check("reg_rst", rd, 0);
        check("osc_rst", {hi_run, lo_run, slow, gpio}, 4'hC);
        wait_run();
        gap("normal_gap", 0, 8);
    endtask
    task automatic t_slow;
        ahb(1, `DCM_OSC_MODE_ADDR, 32'h04);
        ahb(0, `DCM_OSC_MODE_ADDR, 0);
        check("slow_rd", rd, 32'h04);
        check("slow", slow, 1);
        gap("slow_gap", 0, 64);
        gap("wdt_gap", 1, 16);
        ahb(1, `DCM_OSC_MODE_ADDR, 32'h06);
        check("stop", {hi_run, lo_run}, 2'h1);
    endtask
    task automatic t_reg;
        ahb(1, `DCM_OSC_MODE_ADDR, 32'hFF);
        ahb(0, `DCM_OSC_MODE_ADDR, 0);
        check("mask_rd", rd, 32'h1E);
        ahb(1, 32'h100, 32'h00);
        ahb(0, 32'h100, 0);
        check("unmapped", rd, 0);
        ahb(1, `DCM_OSC_MODE_ADDR, 32'h18);
        check("rsvd_mode", mode, 2'h3);
        gap("rsvd_gap", 0, 8);
    endtask
    task automatic t_green;
        wdt_en <= 0;
        ahb(1, `DCM_OSC_MODE_ADDR, 32'h14);
        check("green_low", lo_run, 0);
        wdt_en <= 1;
        @(posedge ref_clk);
        @(posedge ref_clk);
        check("green_wdt", lo_run, 1);
        wake();
        check("green_wake", {mode, slow, run}, 4'h3);
    endtask
    task automatic t_sleep;
        ahb(1, `DCM_OSC_MODE_ADDR, 32'h0C);
        check("sleep_osc", {hi_run, lo_run}, 2'h0);
        repeat (20) @(posedge ref_clk);
        check("sleep_idle", {tick, wtick, run}, 3'h1);
        wake();
        check("sleep_wake", {mode, slow}, 3'h0);
        @(posedge ref_clk);
        check("wake_wait", run, 0);
        wait_run();
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        arst_n <= 1;
        @(posedge ref_clk);
        t_reset();
        t_slow();
        t_reg();
        t_green();
        t_sleep();
        summarize();
    end
    initial begin
        #100000;
        miscompares++;
        summarize();
    end
endmodule // tb_top
